// ===== ppr_divider.sv
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module ppr_divider #(
	parameter int W = 32
) (
	input  wire logic         mclk,
	input  wire logic         arst_n,
	input  wire logic         start,
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	output logic              busy,
	output logic              done,
	output logic [W-1:0]      quot
);
	localparam int CW = $clog2(W + 1);
	logic [W:0]  rem_q;
	logic [W:0]  trial;
	logic [CW-1:0] cnt_q;

	assign trial = {rem_q[W-1:0], quot[W-1]};

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rem_q <= '0;
			quot  <= '0;
			cnt_q <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				rem_q <= '0;
				quot  <= num;
				cnt_q <= CW'(W);
				busy  <= 1'b1;
			end else if (busy) begin
				if (trial >= {1'b0, den}) begin
					rem_q <= trial - {1'b0, den};
					quot  <= {quot[W-2:0], 1'b1};
				end else begin
					rem_q <= trial;
					quot  <= {quot[W-2:0], 1'b0};
				end
				cnt_q <= cnt_q - CW'(1);
				if (cnt_q == CW'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : ppr_divider

// ===== ppr_host_model.sv
// serial host model sending ascii feedback frames
`timescale 1ns/1ps
module ppr_host_model (
	input  wire logic           mclk,
	input  wire logic           go,
	input  wire logic           bad,
	input  wire logic [15:0]    hz100,
	output ppr_pkg::ppr_ascii_s ascii_frame,
	output logic                ascii_valid
);
	int v;
	initial begin
		ascii_valid = 1'b0;
		ascii_frame = '0;
	end
	always @(posedge mclk) begin
		if (go) begin
			#1;
			v = hz100;
			ascii_frame.cmd = bad ? 8'h02 : ppr_pkg::PPR_CMD_FEEDBACK;
			ascii_frame.chars[5] = ppr_pkg::PPR_CHR_ONE;
			for (int i = 0; i < 5; i++) begin
				ascii_frame.chars[i] = ppr_pkg::PPR_CHR_ZERO + 8'(v % 10);
				v = v / 10;
			end
			ascii_valid = 1'b1;
			@(posedge mclk);
			#1;
			ascii_valid = 1'b0;
			ascii_frame = ~ascii_frame;
		end
	end
endmodule : ppr_host_model

// ===== ppr_pkg.sv
// constants and types shared by the process regulator
// Summary of operation
// - selector 01/02 runs regulator, 00 bypasses
// - disable input suspends regulation, passes target through
// - accepts gain, integral and derivative settings
// - monitor equals feedback times scale factor divided by 100
// - feedback source picks current/voltage/serial/pulse/arith
// - target from frequency source, feedback terminal excluded in terminal mode
// - terminal source ignores analog current select
// - bipolar selector forms target from remaining input
// - invert selector 01 negates deviation
// - variation range 0.0 to 100.0 percent
// - feed-forward selects none, voltage, current, bipolar
// - deviation threshold drives deviation flag
// - off and on levels drive compare flag
// - marker digit then five ASCII digits carry frequency times 100
// - ASCII feedback always means hertz
// - Modbus feedback register process_feedback_value, 10000 is 100%
// - register readable only with Modbus feedback source
// - pulse frequency scaled to percent of maximum
// - normal clamps negative to zero, 02 inverts
// - normal mode with nonzero range keeps output within target plus/minus range
// - integral clear input zeroes integral on rising edge
// - deviation flag when magnitude exceeds threshold
package ppr_pkg;
	localparam logic [7:0]  PPR_EN_OFF     = 8'h00;
	localparam logic [7:0]  PPR_EN_NORMAL  = 8'h01;
	localparam logic [7:0]  PPR_EN_INVERT  = 8'h02;
	localparam logic [7:0]  PPR_FB_CURRENT = 8'h00;
	localparam logic [7:0]  PPR_FB_VOLTAGE = 8'h01;
	localparam logic [7:0]  PPR_FB_SERIAL  = 8'h02;
	localparam logic [7:0]  PPR_FB_PULSE   = 8'h03;
	localparam logic [7:0]  PPR_FB_ARITH   = 8'h10;
	localparam logic [7:0]  PPR_FS_ANALOG  = 8'h00;
	localparam logic [7:0]  PPR_FS_TERM    = 8'h01;
	localparam logic [7:0]  PPR_BI_REV     = 8'h02;
	localparam logic [7:0]  PPR_BI_SINGLE  = 8'h03;
	localparam logic [7:0]  PPR_INV_ON     = 8'h01;
	localparam logic [7:0]  PPR_FF_VOLTAGE = 8'h01;
	localparam logic [7:0]  PPR_FF_CURRENT = 8'h02;
	localparam logic [7:0]  PPR_FF_BIPOLAR = 8'h03;
	localparam logic [7:0]  PPR_PROTO_ASCII  = 8'h00;
	localparam logic [7:0]  PPR_PROTO_MODBUS = 8'h01;
	localparam logic [7:0]  PPR_CMD_FEEDBACK = 8'h01;
	localparam logic [7:0]  PPR_CHR_ZERO   = 8'h30;
	localparam logic [7:0]  PPR_CHR_ONE    = 8'h31;
	localparam logic [7:0]  PPR_CHR_NINE   = 8'h39;
	localparam logic [15:0] PPR_REG_FEEDBACK = 16'h0006;
	localparam logic [15:0] PPR_FB_RESET   = 16'h0000;
	localparam int PPR_PCT_FULL   = 10000;
	localparam int PPR_LEVEL_MUL  = 10;
	localparam int PPR_KP_DIV     = 10;
	localparam int PPR_SCALE_DIV  = 100;
	localparam int PPR_CLK_MHZ    = 25;
	localparam int PPR_SAMPLE_US  = 1000;
	localparam int PPR_SAMPLE_MS  = PPR_SAMPLE_US / 1000;
	localparam int PPR_SAMPLE_CYC = PPR_SAMPLE_US * PPR_CLK_MHZ;
	localparam int PPR_TI_UNIT_MS = 100;
	localparam int PPR_TD_UNIT_MS = 10;
	localparam int PPR_TD_MUL     = PPR_TD_UNIT_MS / PPR_SAMPLE_MS;
	localparam int PPR_ASCII_DIG  = 5;

	typedef struct packed {
		logic [7:0]  regulator_enable_sel;
		logic [7:0]  proportional_gain;
		logic [15:0] integral_time;
		logic [15:0] derivative_gain;
		logic [15:0] pv_scale_factor;
		logic [7:0]  feedback_source_sel;
		logic [7:0]  deviation_invert_sel;
		logic [15:0] variation_range;
		logic [7:0]  feedforward_source_sel;
		logic [7:0]  frequency_source_sel;
		logic [7:0]  bipolar_input_sel;
		logic [7:0]  comm_protocol_sel;
		logic [15:0] deviation_threshold;
		logic [15:0] compare_off_level;
		logic [15:0] compare_on_level;
		logic [15:0] max_freq_hz100;
		logic        arith_uses_current;
	} ppr_cfg_s;

	typedef struct packed {
		logic [15:0]        current_loop_input;
		logic [15:0]        voltage_input;
		logic signed [15:0] bipolar_analog_input;
		logic [15:0]        arith_result;
		logic [15:0]        pulse_freq_hz100;
		logic [15:0]        target_setpoint;
	} ppr_inputs_s;

	typedef struct packed {
		logic [7:0]       cmd;
		logic [5:0][7:0]  chars;
	} ppr_ascii_s;
endpackage : ppr_pkg

// ===== ppr_regulator.sv
// closed-loop process regulator with feedback selection and flags
`timescale 1ns/1ps
module ppr_regulator #(
	parameter int SAMPLE_CYC = ppr_pkg::PPR_SAMPLE_CYC
) (
	input  wire logic                mclk,
	input  wire logic                arst_n,
	input  wire ppr_pkg::ppr_cfg_s   cfg,
	input  wire ppr_pkg::ppr_inputs_s ain,
	input  wire logic                analog_current_select,
	input  wire logic                pid_disable_input,
	input  wire logic                integral_clear_input,
	input  wire logic                ascii_valid,
	input  wire ppr_pkg::ppr_ascii_s ascii_frame,
	input  wire logic [15:0]         reg_addr,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [15:0]         reg_wdata,
	output logic [15:0]              reg_rdata,
	output logic                     reg_ack,
	output logic                     reg_refused,
	output logic [15:0]              freq_cmd_pct,
	output logic                     freq_cmd_reverse,
	output logic                     regulating,
	output logic                     deviation_exceeded_flag,
	output logic                     feedback_compare_flag,
	output logic signed [31:0]       feedback_monitor
);
	localparam int TW = $clog2(SAMPLE_CYC);
	localparam logic signed [31:0] FULL = 32'(ppr_pkg::PPR_PCT_FULL);
	localparam logic signed [31:0] ISAT = 32'sh3FFFFFFF;

	typedef enum logic [2:0] {
		S_IDLE, S_FB_DIV, S_ERR, S_I_DIV, S_CALC, S_OUT
	} ppr_state_e;

	ppr_state_e          state_q;
	logic [TW-1:0]       tick_cnt_q;
	logic                tick;
	logic [15:0]         modbus_fb_q;
	logic [16:0]         ascii_hz100_q;
	logic signed [31:0]  fb_q;
	logic signed [31:0]  target_q;
	logic signed [31:0]  err_q;
	logic signed [31:0]  err_prev_q;
	logic signed [31:0]  i_sum_q;
	logic signed [31:0]  i_term_q;
	logic signed [31:0]  d_term_q;
	logic signed [31:0]  sum_q;
	logic                clr_prev_q;
	logic                clr_pend_q;
	logic signed [31:0]  target_w;
	logic signed [31:0]  remain_w;
	logic signed [31:0]  direct_fb_w;
	logic signed [31:0]  ff_w;
	logic signed [31:0]  err_w;
	logic signed [31:0]  i_next_w;
	logic signed [31:0]  u_w;
	logic signed [31:0]  lim_w;
	logic signed [31:0]  kp_y;
	logic signed [31:0]  d_y;
	logic signed [31:0]  mon_y;
	logic                need_div;
	logic [15:0]         div_src;
	logic                div_start;
	logic [31:0]         div_num;
	logic [31:0]         div_den;
	logic                div_busy;
	logic                div_done;
	logic [31:0]         div_quot;
	logic                ascii_ok;
	logic [16:0]         ascii_val;
	logic                modbus_fb_sel;
	logic                run_pid;

	assign tick = (tick_cnt_q == TW'(SAMPLE_CYC - 1));

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			tick_cnt_q <= '0;
		else if (tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + TW'(1);
	end

	assign run_pid = !pid_disable_input &&
		(cfg.regulator_enable_sel == ppr_pkg::PPR_EN_NORMAL ||
		 cfg.regulator_enable_sel == ppr_pkg::PPR_EN_INVERT);

	// target: in terminal mode the feedback terminal never forms the target
	always_comb begin
		if (cfg.feedback_source_sel == ppr_pkg::PPR_FB_CURRENT)
			remain_w = 32'(ain.voltage_input);
		else if (cfg.feedback_source_sel == ppr_pkg::PPR_FB_VOLTAGE)
			remain_w = 32'(ain.current_loop_input);
		else if (cfg.arith_uses_current)
			remain_w = 32'(ain.voltage_input);
		else
			remain_w = 32'(ain.current_loop_input);
		if (cfg.frequency_source_sel == ppr_pkg::PPR_FS_TERM) begin
			case (cfg.bipolar_input_sel)
				ppr_pkg::PPR_BI_SINGLE: target_w = remain_w;
				ppr_pkg::PPR_BI_REV:
					target_w = remain_w + 32'(ain.bipolar_analog_input);
				default: begin
					target_w = remain_w + 32'(ain.bipolar_analog_input);
					if (target_w < 0)
						target_w = '0;
				end
			endcase
		end else if (cfg.frequency_source_sel == ppr_pkg::PPR_FS_ANALOG) begin
			// current select only matters off the terminal block
			if (analog_current_select)
				target_w = 32'(ain.current_loop_input);
			else
				target_w = 32'(ain.voltage_input);
		end else begin
			target_w = 32'(ain.target_setpoint);
		end
	end

	// feedback source selection
	assign modbus_fb_sel =
		cfg.feedback_source_sel == ppr_pkg::PPR_FB_SERIAL &&
		cfg.comm_protocol_sel == ppr_pkg::PPR_PROTO_MODBUS;

	always_comb begin
		need_div = 1'b0;
		div_src  = ain.pulse_freq_hz100;
		case (cfg.feedback_source_sel)
			ppr_pkg::PPR_FB_CURRENT:
				direct_fb_w = 32'(ain.current_loop_input);
			ppr_pkg::PPR_FB_VOLTAGE:
				direct_fb_w = 32'(ain.voltage_input);
			ppr_pkg::PPR_FB_SERIAL: begin
				direct_fb_w = 32'(modbus_fb_q);
				if (!modbus_fb_sel) begin
					need_div = 1'b1;
					div_src  = ascii_hz100_q[16] ? 16'hFFFF
						: ascii_hz100_q[15:0];
				end
			end
			ppr_pkg::PPR_FB_PULSE: begin
				direct_fb_w = '0;
				need_div    = 1'b1;
			end
			ppr_pkg::PPR_FB_ARITH:
				direct_fb_w = 32'(ain.arith_result);
			default:
				direct_fb_w = '0;
		endcase
	end

	always_comb begin
		case (cfg.feedforward_source_sel)
			ppr_pkg::PPR_FF_VOLTAGE: ff_w = 32'(ain.voltage_input);
			ppr_pkg::PPR_FF_CURRENT: ff_w = 32'(ain.current_loop_input);
			ppr_pkg::PPR_FF_BIPOLAR: ff_w = 32'(ain.bipolar_analog_input);
			default:                 ff_w = '0;
		endcase
	end

	// ascii feedback frame: command, marker digit, five digits
	always_comb begin
		ascii_ok  = ascii_frame.cmd == ppr_pkg::PPR_CMD_FEEDBACK &&
			ascii_frame.chars[5] == ppr_pkg::PPR_CHR_ONE;
		ascii_val = '0;
		for (int k = ppr_pkg::PPR_ASCII_DIG - 1; k >= 0; k--) begin
			if (ascii_frame.chars[k] < ppr_pkg::PPR_CHR_ZERO ||
			    ascii_frame.chars[k] > ppr_pkg::PPR_CHR_NINE)
				ascii_ok = 1'b0;
			ascii_val = 17'(ascii_val * 17'd10 +
				17'(ascii_frame.chars[k] - ppr_pkg::PPR_CHR_ZERO));
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			ascii_hz100_q <= '0;
		else if (ascii_valid && ascii_ok &&
		         cfg.comm_protocol_sel == ppr_pkg::PPR_PROTO_ASCII)
			ascii_hz100_q <= ascii_val;
	end

	// feedback holding register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			modbus_fb_q <= ppr_pkg::PPR_FB_RESET;
			reg_rdata   <= '0;
			reg_ack     <= 1'b0;
			reg_refused <= 1'b0;
		end else begin
			reg_ack     <= 1'b0;
			reg_refused <= 1'b0;
			if (reg_addr != ppr_pkg::PPR_REG_FEEDBACK) begin
				reg_refused <= reg_wr || reg_rd;
			end else if (reg_wr) begin
				reg_ack <= 1'b1;
				if (32'(reg_wdata) > FULL)
					modbus_fb_q <= 16'(FULL);
				else
					modbus_fb_q <= reg_wdata;
			end else if (reg_rd) begin
				if (modbus_fb_sel) begin
					reg_ack   <= 1'b1;
					reg_rdata <= modbus_fb_q;
				end else begin
					reg_refused <= 1'b1;
				end
			end
		end
	end

	// integral clear: edge held pending until the next sample
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			clr_prev_q <= 1'b0;
			clr_pend_q <= 1'b0;
		end else begin
			clr_prev_q <= integral_clear_input;
			if (integral_clear_input && !clr_prev_q)
				clr_pend_q <= 1'b1;
			else if (state_q == S_ERR)
				clr_pend_q <= 1'b0;
		end
	end

	assign div_num = state_q == S_IDLE || state_q == S_FB_DIV
		? 32'(div_src) * 32'(ppr_pkg::PPR_PCT_FULL)
		: (i_sum_q < 0 ? 32'(-i_sum_q) : 32'(i_sum_q));
	assign div_den = state_q == S_IDLE || state_q == S_FB_DIV
		? 32'(cfg.max_freq_hz100)
		: 32'(cfg.integral_time) * 32'(ppr_pkg::PPR_TI_UNIT_MS);
	assign div_start = (state_q == S_IDLE && tick && need_div &&
		cfg.max_freq_hz100 != '0) ||
		(state_q == S_ERR && cfg.integral_time != '0);

	ppr_divider #(.W(32)) u_div (
		.mclk  (mclk),
		.arst_n(arst_n),
		.start (div_start),
		.num   (div_num),
		.den   (div_den),
		.busy  (div_busy),
		.done  (div_done),
		.quot  (div_quot)
	);

	always_comb begin
		err_w = target_q - fb_q;
		if (cfg.deviation_invert_sel == ppr_pkg::PPR_INV_ON)
			err_w = -err_w;
		i_next_w = i_sum_q + err_w * 32'(ppr_pkg::PPR_SAMPLE_MS);
		if (i_next_w > ISAT)
			i_next_w = ISAT;
		else if (i_next_w < -ISAT)
			i_next_w = -ISAT;
	end

	ppr_sat_mul #(.WA(32), .WB(16), .WO(32),
		.MUL(ppr_pkg::PPR_TD_MUL), .DIV(1)) u_dmul (
		.a(err_q - err_prev_q),
		.b(cfg.derivative_gain),
		.y(d_y)
	);

	ppr_sat_mul #(.WA(32), .WB(8), .WO(32),
		.MUL(1), .DIV(ppr_pkg::PPR_KP_DIV)) u_kpmul (
		.a(sum_q),
		.b(cfg.proportional_gain),
		.y(kp_y)
	);

	ppr_sat_mul #(.WA(32), .WB(16), .WO(32),
		.MUL(1), .DIV(ppr_pkg::PPR_SCALE_DIV)) u_monmul (
		.a(fb_q),
		.b(cfg.pv_scale_factor),
		.y(mon_y)
	);

	// sample sequence: feedback, deviation, integral, sum, output
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q    <= S_IDLE;
			fb_q       <= '0;
			target_q   <= '0;
			err_q      <= '0;
			err_prev_q <= '0;
			i_sum_q    <= '0;
			i_term_q   <= '0;
			d_term_q   <= '0;
			sum_q      <= '0;
		end else begin
			case (state_q)
				S_IDLE: if (tick) begin
					target_q <= target_w;
					if (!need_div) begin
						fb_q    <= direct_fb_w;
						state_q <= S_ERR;
					end else if (cfg.max_freq_hz100 == '0) begin
						fb_q    <= '0;
						state_q <= S_ERR;
					end else begin
						state_q <= S_FB_DIV;
					end
				end
				S_FB_DIV: if (div_done) begin
					fb_q    <= div_quot > 32'hFFFF ? 32'hFFFF
						: {16'h0, div_quot[15:0]};
					state_q <= S_ERR;
				end
				S_ERR: begin
					err_prev_q <= err_q;
					err_q      <= err_w;
					if (clr_pend_q)
						i_sum_q <= '0;
					else if (run_pid && cfg.integral_time != '0)
						i_sum_q <= i_next_w;
					if (cfg.integral_time == '0) begin
						i_term_q <= '0;
						state_q  <= S_CALC;
					end else begin
						state_q <= S_I_DIV;
					end
				end
				S_I_DIV: if (div_done) begin
					i_term_q <= i_sum_q < 0 ? -$signed(div_quot)
						: $signed(div_quot);
					state_q  <= S_CALC;
				end
				S_CALC: begin
					d_term_q <= d_y;
					sum_q    <= err_q + i_term_q + d_y;
					state_q  <= S_OUT;
				end
				S_OUT: state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	assign lim_w = 32'(cfg.variation_range) * ppr_pkg::PPR_LEVEL_MUL;

	// output shaping
	always_comb begin
		u_w = kp_y + ff_w;
		if (cfg.regulator_enable_sel == ppr_pkg::PPR_EN_NORMAL &&
		    cfg.variation_range != '0) begin
			if (u_w > target_q + lim_w)
				u_w = target_q + lim_w;
			else if (u_w < target_q - lim_w)
				u_w = target_q - lim_w;
		end
		if (!run_pid)
			u_w = target_q;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			freq_cmd_pct     <= '0;
			freq_cmd_reverse <= 1'b0;
			regulating       <= 1'b0;
		end else if (state_q == S_OUT) begin
			regulating <= run_pid;
			if (u_w < 0 && run_pid &&
			    cfg.regulator_enable_sel == ppr_pkg::PPR_EN_NORMAL) begin
				freq_cmd_pct     <= '0;
				freq_cmd_reverse <= 1'b0;
			end else begin
				freq_cmd_reverse <= u_w < 0;
				if ((u_w < 0 ? -u_w : u_w) > FULL)
					freq_cmd_pct <= 16'(FULL);
				else
					freq_cmd_pct <= 16'(u_w < 0 ? -u_w : u_w);
			end
		end
	end

	// status flags and monitor
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			deviation_exceeded_flag <= 1'b0;
			feedback_compare_flag   <= 1'b0;
			feedback_monitor        <= '0;
		end else begin
			feedback_monitor <= mon_y;
			deviation_exceeded_flag <= (err_q < 0 ? -err_q : err_q) >
				32'(cfg.deviation_threshold) *
				ppr_pkg::PPR_LEVEL_MUL;
			if (fb_q > 32'(cfg.compare_on_level) * ppr_pkg::PPR_LEVEL_MUL)
				feedback_compare_flag <= 1'b1;
			else if (fb_q < 32'(cfg.compare_off_level) *
			         ppr_pkg::PPR_LEVEL_MUL)
				feedback_compare_flag <= 1'b0;
		end
	end
endmodule : ppr_regulator

// ===== ppr_regulator_props.sv
// concurrent checks on the regulator ports
`timescale 1ns/1ps
module ppr_regulator_props #(
	parameter int SAMPLE_CYC = ppr_pkg::PPR_SAMPLE_CYC
) (
	input wire logic                 mclk,
	input wire logic                 arst_n,
	input wire ppr_pkg::ppr_cfg_s    cfg,
	input wire ppr_pkg::ppr_inputs_s ain,
	input wire logic                 pid_disable_input,
	input wire logic [15:0]          reg_addr,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic                 reg_ack,
	input wire logic                 reg_refused,
	input wire logic [15:0]          freq_cmd_pct,
	input wire logic                 freq_cmd_reverse,
	input wire logic                 regulating
);
	int   byp_cnt;
	logic hit;
	logic mb;
	logic nrm;
	logic tsp;
	assign hit = reg_addr == ppr_pkg::PPR_REG_FEEDBACK;
	assign mb = cfg.feedback_source_sel == ppr_pkg::PPR_FB_SERIAL &&
		cfg.comm_protocol_sel == ppr_pkg::PPR_PROTO_MODBUS;
	assign nrm = cfg.regulator_enable_sel == ppr_pkg::PPR_EN_NORMAL;
	assign tsp = cfg.frequency_source_sel > ppr_pkg::PPR_FS_TERM;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			byp_cnt <= 0;
		else if (cfg.regulator_enable_sel != ppr_pkg::PPR_EN_OFF &&
			!pid_disable_input)
			byp_cnt <= 0;
		else if (byp_cnt < 2 * SAMPLE_CYC)
			byp_cnt <= byp_cnt + 1;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	property p_wr_ack;
		reg_wr && hit |=> reg_ack && !reg_refused;
	endproperty
	a_wr_ack: assert property (p_wr_ack)
		else $error("write not acked");
	property p_bad_addr;
		(reg_wr || reg_rd) && !hit |=> reg_refused && !reg_ack;
	endproperty
	a_bad_addr: assert property (p_bad_addr)
		else $error("bad address not refused");
	property p_idle;
		!reg_wr && !reg_rd |=> !reg_ack && !reg_refused;
	endproperty
	a_idle: assert property (p_idle)
		else $error("answer without request");
	property p_rd_ok;
		reg_rd && !reg_wr && hit && mb |=> reg_ack;
	endproperty
	a_rd_ok: assert property (p_rd_ok)
		else $error("read not acked");
	property p_rd_no;
		reg_rd && !reg_wr && hit && !mb |=> reg_refused && !reg_ack;
	endproperty
	a_rd_no: assert property (p_rd_no)
		else $error("read not refused");
	property p_bypass;
		byp_cnt == 2 * SAMPLE_CYC && tsp |->
		!regulating && freq_cmd_pct == ain.target_setpoint;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass output wrong");
	property p_no_rev;
		regulating && nrm |-> !freq_cmd_reverse;
	endproperty
	a_no_rev: assert property (p_no_rev)
		else $error("reverse in normal mode");
	property p_range;
		regulating && nrm && tsp && cfg.variation_range != 16'h0000 |->
		32'(freq_cmd_pct) <= ain.target_setpoint + 10 * cfg.variation_range
		&& freq_cmd_pct + 10 * cfg.variation_range >= 32'(ain.target_setpoint);
	endproperty
	a_range: assert property (p_range)
		else $error("output outside range");
	property p_stand;
		$changed(freq_cmd_pct) |=> $stable(freq_cmd_pct) [*8];
	endproperty
	a_stand: assert property (p_stand)
		else $error("command not held");
endmodule : ppr_regulator_props

bind ppr_regulator ppr_regulator_props #(.SAMPLE_CYC(SAMPLE_CYC))
	i_ppr_regulator_props (.*);

// ===== ppr_sat_mul.sv
// signed times unsigned, scaled by MUL/DIV, saturated to WO bits
`timescale 1ns/1ps
module ppr_sat_mul #(
	parameter int WA  = 32,
	parameter int WB  = 16,
	parameter int WO  = 32,
	parameter int MUL = 1,
	parameter int DIV = 1
) (
	input  wire logic signed [WA-1:0] a,
	input  wire logic [WB-1:0]        b,
	output logic signed [WO-1:0]      y
);
	localparam logic signed [63:0] MAXV = (64'sd1 <<< (WO - 1)) - 64'sd1;
	localparam logic signed [63:0] MINV = -(64'sd1 <<< (WO - 1));
	logic signed [63:0] p;

	always_comb begin
		p = 64'(a) * $signed({48'h0, b}) * 64'(MUL);
		p = p / 64'(DIV);
		if (p > MAXV)
			y = MAXV[WO-1:0];
		else if (p < MINV)
			y = MINV[WO-1:0];
		else
			y = p[WO-1:0];
	end
endmodule : ppr_sat_mul

// ===== test_ppr_regulator.sv
// self-checking bench for the process regulator
`timescale 1ns/1ps
module test_ppr_regulator;
	localparam int SC = 200;
	localparam int MAXF = 6000;
	localparam logic [15:0] RF = ppr_pkg::PPR_REG_FEEDBACK;
	logic                 mclk;
	logic                 arst_n;
	ppr_pkg::ppr_cfg_s    cfg;
	ppr_pkg::ppr_inputs_s ain;
	logic                 analog_current_select;
	logic                 pid_disable_input;
	logic                 integral_clear_input;
	logic                 ascii_valid;
	ppr_pkg::ppr_ascii_s  ascii_frame;
	logic [15:0]          reg_addr;
	logic                 reg_wr;
	logic                 reg_rd;
	logic [15:0]          reg_wdata;
	logic [15:0]          reg_rdata;
	logic                 reg_ack;
	logic                 reg_refused;
	logic [15:0]          freq_cmd_pct;
	logic                 freq_cmd_reverse;
	logic                 regulating;
	logic                 deviation_exceeded_flag;
	logic                 feedback_compare_flag;
	logic signed [31:0]   feedback_monitor;
	logic                 go;
	logic                 bad;
	logic [15:0]          hz100;
	logic [7:0]           srcs [4] = '{8'h00, 8'h01, 8'h03, 8'h10};
	int                   err_total;
	int                   total_checks;
	int                   cmp;
	int                   t;
	int                   f;

	ppr_regulator #(.SAMPLE_CYC(SC)) i_ppr_regulator (.*);
	ppr_host_model i_ppr_host_model (.*);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic start;
		arst_n = 1'b0;
		cmp = 0;
		repeat (4) @(posedge mclk);
		#1;
		arst_n = 1'b1;
	endtask : start

	task automatic reg_op(input logic w, input logic [15:0] a,
		input logic [15:0] d, input logic ok, input logic [15:0] x);
		@(posedge mclk);
		#1;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		chk(reg_ack, ok);
		chk(reg_refused, !ok);
		if (ok && !w)
			chk(reg_rdata, x);
	endtask : reg_op

	task automatic send(input int v, input bit b);
		hz100 = 16'(v);
		bad = b;
		go = 1'b1;
		@(posedge mclk);
		#1;
		go = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
	endtask : send

	task automatic run(input bit rst, input int tg, input int raw,
		input int fbp);
		int e;
		int o;
		int r;
		bit byp;
		if (rst)
			start();
		ain.target_setpoint = 16'(tg);
		if (raw >= 0 && cfg.comm_protocol_sel == ppr_pkg::PPR_PROTO_MODBUS)
			reg_op(1'b1, RF, 16'(raw), 1'b1, 16'h0);
		else if (raw >= 0)
			send(raw, 1'b0);
		repeat (2 * SC + 100) @(posedge mclk);
		#1;
		byp = pid_disable_input ||
			cfg.regulator_enable_sel == ppr_pkg::PPR_EN_OFF;
		e = cfg.deviation_invert_sel == ppr_pkg::PPR_INV_ON ? fbp - tg : tg - fbp;
		o = e * int'(cfg.proportional_gain) / 10;
		r = 10 * int'(cfg.variation_range);
		if (cfg.regulator_enable_sel == ppr_pkg::PPR_EN_NORMAL && r != 0)
			o = o > tg + r ? tg + r : (o < tg - r ? tg - r : o);
		if (cfg.regulator_enable_sel == ppr_pkg::PPR_EN_NORMAL && o < 0)
			o = 0;
		if (byp)
			o = tg;
		chk(freq_cmd_pct, o < 0 ? -o : o);
		chk(freq_cmd_reverse, o < 0);
		chk(regulating, !byp);
		if (!byp) begin
			if (fbp > 10 * int'(cfg.compare_on_level))
				cmp = 1;
			else if (fbp < 10 * int'(cfg.compare_off_level))
				cmp = 0;
			r = 10 * int'(cfg.deviation_threshold);
			chk(deviation_exceeded_flag, (e < 0 ? -e : e) > r);
			chk(feedback_compare_flag, cmp[0]);
			chk(feedback_monitor, fbp * int'(cfg.pv_scale_factor) / 100);
		end
	endtask : run

	initial begin
		arst_n = 1'b0;
		{cfg, ain} = '0;
		{analog_current_select, pid_disable_input, integral_clear_input} = '0;
		{reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
		{go, bad, hz100} = '0;
		err_total = 0;
		total_checks = 0;
		void'($urandom(32'h6a067198));
		cfg.regulator_enable_sel = ppr_pkg::PPR_EN_NORMAL;
		cfg.proportional_gain = 8'h0A;
		cfg.feedback_source_sel = ppr_pkg::PPR_FB_SERIAL;
		cfg.comm_protocol_sel = ppr_pkg::PPR_PROTO_MODBUS;
		cfg.frequency_source_sel = 8'h02;
		cfg.max_freq_hz100 = 16'(MAXF);
		cfg.deviation_threshold = 16'h0064;
		cfg.compare_off_level = 16'h012C;
		cfg.compare_on_level = 16'h01F4;
		cfg.pv_scale_factor = 16'($urandom_range(9999, 1));
		start();
		f = $urandom_range(10000);
		reg_op(1'b1, RF, 16'(f), 1'b1, 16'h0);
		reg_op(1'b0, RF, 16'h0, 1'b1, 16'(f));
		reg_op(1'b1, RF, 16'hFFFF, 1'b1, 16'h0);
		reg_op(1'b0, RF, 16'h0, 1'b1, 16'h2710);
		reg_op(1'b1, 16'h0007, 16'h0001, 1'b0, 16'h0);
		reg_op(1'b0, 16'h0005, 16'h0000, 1'b0, 16'h0);
		foreach (srcs[i]) begin
			cfg.feedback_source_sel = srcs[i];
			reg_op(1'b0, RF, 16'h0, 1'b0, 16'h0);
		end
		cfg.feedback_source_sel = ppr_pkg::PPR_FB_SERIAL;
		cfg.comm_protocol_sel = ppr_pkg::PPR_PROTO_ASCII;
		reg_op(1'b0, RF, 16'h0, 1'b0, 16'h0);
		cfg.comm_protocol_sel = ppr_pkg::PPR_PROTO_MODBUS;
		repeat (4) begin
			t = $urandom_range(8000, 2000);
			f = $urandom_range(10000);
			run(1'b1, t, f, f);
		end
		run(1'b1, 5000, 6000, 6000);
		run(1'b0, 5000, 4000, 4000);
		run(1'b0, 5000, 2000, 2000);
		cfg.deviation_invert_sel = ppr_pkg::PPR_INV_ON;
		run(1'b1, 3000, 5000, 5000);
		cfg.deviation_invert_sel = 8'h00;
		cfg.regulator_enable_sel = ppr_pkg::PPR_EN_INVERT;
		run(1'b1, 3000, 5000, 5000);
		cfg.variation_range = 16'h0032;
		run(1'b1, 6000, 1000, 1000);
		cfg.regulator_enable_sel = ppr_pkg::PPR_EN_NORMAL;
		run(1'b1, 6000, 1000, 1000);
		run(1'b1, 3000, 2000, 2000);
		cfg.variation_range = 16'h0000;
		cfg.proportional_gain = 8'($urandom_range(50, 2));
		run(1'b1, 3000, 2000, 2000);
		cfg.proportional_gain = 8'h0A;
		cfg.regulator_enable_sel = ppr_pkg::PPR_EN_OFF;
		run(1'b1, 4321, 1000, 1000);
		cfg.regulator_enable_sel = ppr_pkg::PPR_EN_NORMAL;
		pid_disable_input = 1'b1;
		run(1'b1, 4321, 1000, 1000);
		pid_disable_input = 1'b0;
		run(1'b0, 4321, -1, 1000);
		cfg.comm_protocol_sel = ppr_pkg::PPR_PROTO_ASCII;
		f = $urandom_range(MAXF);
		t = f * 10000 / MAXF;
		run(1'b1, 5000, f, t);
		send(1234, 1'b1);
		run(1'b0, 5000, -1, t);
		cfg.feedback_source_sel = ppr_pkg::PPR_FB_PULSE;
		ain.pulse_freq_hz100 = 16'(f);
		run(1'b1, 5000, -1, t);
		ain.current_loop_input = 16'($urandom_range(10000));
		ain.voltage_input = 16'($urandom_range(10000));
		ain.arith_result = 16'($urandom_range(10000));
		cfg.feedback_source_sel = ppr_pkg::PPR_FB_CURRENT;
		run(1'b1, 5000, -1, ain.current_loop_input);
		cfg.feedback_source_sel = ppr_pkg::PPR_FB_VOLTAGE;
		run(1'b1, 5000, -1, ain.voltage_input);
		cfg.feedback_source_sel = ppr_pkg::PPR_FB_ARITH;
		run(1'b1, 5000, -1, ain.arith_result);
		test_done();
	end
endmodule : test_ppr_regulator
